// >>> verilog/spo_status_pin_ctrl.sv
// status pin output control register and the two monitor pin channels
//
// Notes on behaviour
// - code 010110 shows loop reference divided by two
// - code 010111 shows phase detector up, halved
// - bit 3 gates pin b, bit 2 pin a
// - bit 1 divides pin a by four
// - bit 0 divides pin b by four
// - bits 7 to 4 reserved, read zero
`timescale 1ns/1ps
`include "spo_consts.svh"

module spo_status_pin_ctrl
  import spo_pkg::*;
#(
  parameter int NUM_DIRECT = `SPO_NUM_DIRECT
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register access from the serial control port
  input wire logic [`SPO_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire spo_byte_t reg_wdata,
  input wire logic reg_rd,
  output spo_byte_t reg_rdata,
  output logic reg_rvalid,
  // select codes held in the neighbouring select registers
  input wire spo_sel_t sel_a,
  input wire spo_sel_t sel_b,
  // monitored signals, from other clock domains
  input wire logic [NUM_DIRECT-1:0] mon_src,
  input wire logic synth_loop_ref,
  input wire logic phase_detector_up,
  // status pins
  output logic monitor_pin_a,
  output logic monitor_pin_b
);

  ////////////////////////////////////////////////////////////////////////////
  // the two halved sources sit at fixed codes right after the direct ones
  if (NUM_DIRECT != `SPO_NUM_DIRECT)
  begin : g_chk
    $error("spo_status_pin_ctrl: NUM_DIRECT must leave codes 22 and 23 free");
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  spo_ctrl_t ctrl_q;
  logic ctrl_hit;

  assign ctrl_hit = (reg_addr == `SPO_CTRL_ADDR);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ctrl_q <= `SPO_CTRL_RESET;
    else if (reg_wr && ctrl_hit)
      ctrl_q <= reg_wdata[3:0];
  end

  // unmapped addresses read zero; reserved nibble is never stored
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata <= `SPO_RDATA_RESET;
    else if (reg_rd)
    begin
      if (ctrl_hit)
        reg_rdata <= {`SPO_RSVD_READ, ctrl_q};
      else
        reg_rdata <= `SPO_RDATA_RESET;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rvalid <= 1'b0;
    else
      reg_rvalid <= reg_rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers; the first stage feeds only the second
  logic [NUM_DIRECT-1:0] mon_s1_q;
  logic [NUM_DIRECT-1:0] mon_s2_q;
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;
  logic pfd_s1_q;
  logic pfd_s2_q;
  logic pfd_s3_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      mon_s1_q <= '0;
      mon_s2_q <= '0;
    end
    else
    begin
      mon_s1_q <= mon_src;
      mon_s2_q <= mon_s1_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end
    else
    begin
      ref_s1_q <= synth_loop_ref;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pfd_s1_q <= 1'b0;
      pfd_s2_q <= 1'b0;
      pfd_s3_q <= 1'b0;
    end
    else
    begin
      pfd_s1_q <= phase_detector_up;
      pfd_s2_q <= pfd_s1_q;
      pfd_s3_q <= pfd_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halving stages; only signals below half of ref_clk survive sampling
  logic ref_div2_q;
  logic pfd_div2_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ref_div2_q <= 1'b0;
    else if (ref_s2_q && !ref_s3_q)
      ref_div2_q <= !ref_div2_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      pfd_div2_q <= 1'b0;
    else if (pfd_s2_q && !pfd_s3_q)
      pfd_div2_q <= !pfd_div2_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels
  logic [`SPO_NUM_SRC-1:0] src_vec;

  assign src_vec = {pfd_div2_q, ref_div2_q, mon_s2_q};

  spo_channel #(
    .NUM_SRC(`SPO_NUM_SRC)
  ) u_chan_a (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .src(src_vec),
    .sel(sel_a),
    .out_en(ctrl_q[`SPO_A_EN_BIT]),
    .div_en(ctrl_q[`SPO_A_DIV_BIT]),
    .pin(monitor_pin_a)
  );

  spo_channel #(
    .NUM_SRC(`SPO_NUM_SRC)
  ) u_chan_b (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .src(src_vec),
    .sel(sel_b),
    .out_en(ctrl_q[`SPO_B_EN_BIT]),
    .div_en(ctrl_q[`SPO_B_DIV_BIT]),
    .pin(monitor_pin_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_gate_a;
    @(posedge ref_clk) disable iff (sys_rst)
    !ctrl_q[`SPO_A_EN_BIT] |=> !monitor_pin_a;
  endproperty
  a_gate_a: assert property (p_gate_a)
    else $error("pin a driven while disabled");

  property p_gate_b;
    @(posedge ref_clk) disable iff (sys_rst)
    !ctrl_q[`SPO_B_EN_BIT] |=> !monitor_pin_b;
  endproperty
  a_gate_b: assert property (p_gate_b)
    else $error("pin b driven while disabled");

  property p_rsvd_read;
    @(posedge ref_clk) disable iff (sys_rst)
    reg_rd |=> (reg_rvalid && (reg_rdata[7:4] == 4'h0));
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved bits read nonzero");

  property p_ctrl_write;
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_wr && ctrl_hit) |=> (ctrl_q == $past(reg_wdata[3:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not stored");

  property p_ref_div;
    @(posedge ref_clk) disable iff (sys_rst)
    (ref_s2_q && !ref_s3_q) |=> (ref_div2_q != $past(ref_div2_q));
  endproperty
  a_ref_div: assert property (p_ref_div)
    else $error("reference halving missed an edge");

  property p_pfd_div;
    @(posedge ref_clk) disable iff (sys_rst)
    !(pfd_s2_q && !pfd_s3_q) |=> $stable(pfd_div2_q);
  endproperty
  a_pfd_div: assert property (p_pfd_div)
    else $error("phase detector halving toggled without an edge");

  sequence s_route_ref_a;
    (sel_a == `SPO_SEL_REF_DIV2 && ctrl_q[`SPO_A_EN_BIT] && !ctrl_q[`SPO_A_DIV_BIT])[*3];
  endsequence

  property p_route_ref_a;
    @(posedge ref_clk) disable iff (sys_rst)
    s_route_ref_a |-> (monitor_pin_a == $past(ref_div2_q, 2));
  endproperty
  a_route_ref_a: assert property (p_route_ref_a)
    else $error("pin a does not show halved reference");

  sequence s_route_pfd_b;
    (sel_b == `SPO_SEL_PFD_DIV2 && ctrl_q[`SPO_B_EN_BIT] && !ctrl_q[`SPO_B_DIV_BIT])[*3];
  endsequence

  property p_route_pfd_b;
    @(posedge ref_clk) disable iff (sys_rst)
    s_route_pfd_b |-> (monitor_pin_b == $past(pfd_div2_q, 2));
  endproperty
  a_route_pfd_b: assert property (p_route_pfd_b)
    else $error("pin b does not show halved phase detector up");

endmodule : spo_status_pin_ctrl

// >>> verilog/spo_consts.svh
// offsets, field positions, codes and reset values of the status pin output control
`ifndef SPO_CONSTS_SVH
`define SPO_CONSTS_SVH

`define SPO_ADDR_W 16
`define SPO_CTRL_ADDR 16'h0507
`define SPO_CTRL_RESET 4'h0
`define SPO_RDATA_RESET 8'h00
`define SPO_RSVD_READ 4'h0

`define SPO_B_DIV_BIT 0
`define SPO_A_DIV_BIT 1
`define SPO_A_EN_BIT 2
`define SPO_B_EN_BIT 3

`define SPO_NUM_DIRECT 22
`define SPO_NUM_SRC 24
`define SPO_SEL_REF_DIV2 6'h16
`define SPO_SEL_PFD_DIV2 6'h17
`define SPO_SEL_LAST 6'h17
`define SPO_SEL_DC_LAST 6'h0F

`endif

// >>> verilog/spo_pkg.sv
// types shared by the status pin output control files
package spo_pkg;
  typedef logic [5:0] spo_sel_t;
  typedef logic [7:0] spo_byte_t;
  typedef logic [3:0] spo_ctrl_t;
  typedef logic [1:0] spo_div_cnt_t;
endpackage : spo_pkg

// >>> verilog/spo_channel.sv
// one monitor channel: source select, divide-by-four stage and output gate
`timescale 1ns/1ps
`include "spo_consts.svh"

module spo_channel
  import spo_pkg::*;
#(
  parameter int NUM_SRC = `SPO_NUM_SRC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // sources, already in this clock domain
  input wire logic [NUM_SRC-1:0] src,
  // settings
  input wire spo_sel_t sel,
  input wire logic out_en,
  input wire logic div_en,
  // pin
  output logic pin
);

  ////////////////////////////////////////////////////////////////////////////
  logic pick_q;
  logic pick_d;
  spo_div_cnt_t cnt_q;

  if (NUM_SRC != `SPO_NUM_SRC)
  begin : g_chk
    $error("spo_channel: NUM_SRC must match the select code space");
  end

  // reserved codes show a quiet low rather than an undefined source
  always_comb
  begin
    pick_d = 1'b0;
    if (sel <= `SPO_SEL_LAST)
    begin
      pick_d = src[sel[4:0]];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      pick_q <= 1'b0;
    else
      pick_q <= pick_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide by four: counts rising edges, msb is the slowed copy
  logic pick_prev_q;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      pick_prev_q <= 1'b0;
    else
      pick_prev_q <= pick_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cnt_q <= 2'h0;
    else if (pick_q && !pick_prev_q)
      cnt_q <= cnt_q + 2'h1;
  end

  // gate last so a disabled pin never glitches with the divider
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      pin <= 1'b0;
    else if (!out_en)
      pin <= 1'b0;
    else if (div_en)
      pin <= cnt_q[1];
    else
      pin <= pick_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_div_count;
    @(posedge ref_clk) disable iff (sys_rst)
    (pick_q && !pick_prev_q) |=> (cnt_q == 2'($past(cnt_q) + 2'h1));
  endproperty
  a_div_count: assert property (p_div_count)
    else $error("divider missed a rising edge");

  property p_div_select;
    @(posedge ref_clk) disable iff (sys_rst)
    (out_en && div_en) |=> (pin == $past(cnt_q[1]));
  endproperty
  a_div_select: assert property (p_div_select)
    else $error("divided pin does not follow counter msb");

  property p_rsvd_code;
    @(posedge ref_clk) disable iff (sys_rst)
    (sel > `SPO_SEL_LAST) |=> !pick_q;
  endproperty
  a_rsvd_code: assert property (p_rsvd_code)
    else $error("reserved select code shows a source");

endmodule : spo_channel

// >>> sim/spo_far_model.sv
// source generator and pin period monitor standing outside the block
`timescale 1ns/1ps

module spo_far_model
(
  // sources
  output logic synth_loop_ref,
  output logic phase_detector_up,
  // pins
  input wire logic pin_a,
  input wire logic pin_b,
  // measurements
  output int per_a,
  output int per_b,
  output int n_a,
  output int n_b
);
  realtime t_a = 0;
  realtime t_b = 0;
  initial
  begin
    per_a = 0;
    per_b = 0;
    n_a = 0;
    n_b = 0;
  end
  //////////////////////////////////////////////////////////////////////
  // periods are whole clock multiples, so each pin period comes out exact
  initial
  begin
    synth_loop_ref = 1'b0;
    #1.3;
    forever #25 synth_loop_ref = ~synth_loop_ref;
  end
  initial
  begin
    phase_detector_up = 1'b0;
    #1.7;
    forever #35 phase_detector_up = ~phase_detector_up;
  end
  //////////////////////////////////////////////////////////////////////
  always @(posedge pin_a)
  begin
    per_a = int'($realtime - t_a);
    t_a = $realtime;
    n_a++;
  end
  always @(posedge pin_b)
  begin
    per_b = int'($realtime - t_b);
    t_b = $realtime;
    n_b++;
  end
endmodule : spo_far_model

// >>> sim/spo_status_pin_ctrl_tb_top.sv
// self-checking bench of the status pin output control
`timescale 1ns/1ps
`include "spo_consts.svh"

module spo_status_pin_ctrl_tb_top
  import spo_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [`SPO_ADDR_W-1:0] reg_addr = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  spo_byte_t reg_wdata = '0;
  spo_byte_t reg_rdata;
  logic reg_rvalid;
  spo_sel_t sel_a = '0;
  spo_sel_t sel_b = '0;
  logic [`SPO_NUM_DIRECT-1:0] mon_src = '0;
  logic synth_loop_ref, phase_detector_up, monitor_pin_a, monitor_pin_b;
  int per_a, per_b, n_a, n_b, fail_count, n_compared, ctrl_m, a0, b0, k;
  logic [31:0] rnd = 32'haec8_e69c;

  always #2.5 ref_clk = ~ref_clk;

  spo_status_pin_ctrl i_spo_status_pin_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sel_a(sel_a), .sel_b(sel_b),
    .mon_src(mon_src), .synth_loop_ref(synth_loop_ref),
    .phase_detector_up(phase_detector_up), .monitor_pin_a(monitor_pin_a),
    .monitor_pin_b(monitor_pin_b));
  spo_far_model i_spo_far_model (.synth_loop_ref(synth_loop_ref),
    .phase_detector_up(phase_detector_up), .pin_a(monitor_pin_a), .pin_b(monitor_pin_b),
    .per_a(per_a), .per_b(per_b), .n_a(n_a), .n_b(n_b));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("counts: compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic reg_write(input logic [15:0] addr, input spo_byte_t data);
    @(negedge ref_clk);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    if (addr === `SPO_CTRL_ADDR)
      ctrl_m = data[3:0];
  endtask : reg_write

  // answer stands for the one cycle after the taking edge
  task automatic reg_read(input logic [15:0] addr, input spo_byte_t exp);
    @(negedge ref_clk);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    check(reg_rvalid, 1'b1);
    check(reg_rdata, exp);
  endtask : reg_read
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    ctrl_m = 0;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    check({monitor_pin_a, monitor_pin_b}, 2'b00);
    reg_read(`SPO_CTRL_ADDR, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr_next(rnd);
      reg_write(`SPO_CTRL_ADDR, rnd[7:0]);
      reg_read(`SPO_CTRL_ADDR, {4'h0, 4'(ctrl_m)});
    end
    reg_write(16'h0508, 8'hff);
    reg_read(`SPO_CTRL_ADDR, {4'h0, 4'(ctrl_m)});
    reg_read(16'h0508, 8'h00);
    $display("test register done");
    for (int c = 0; c < `SPO_NUM_DIRECT; c++)
    begin
      rnd = lfsr_next(rnd);
      mon_src = rnd[21:0];
      sel_a = 6'(c);
      sel_b = 6'(21 - c);
      // static codes, dividers kept off
      reg_write(`SPO_CTRL_ADDR, {4'h0, rnd[31:30], 2'b00});
      repeat (8) @(negedge ref_clk);
      check(monitor_pin_a, ctrl_m[2] ? mon_src[c] : 1'b0);
      check(monitor_pin_b, ctrl_m[3] ? mon_src[21 - c] : 1'b0);
    end
    $display("test static codes done");
    for (int i = 0; i < 5; i++)
    begin
      // codes stay at or below 010111
      sel_a = (i < 4) ? `SPO_SEL_REF_DIV2 : `SPO_SEL_PFD_DIV2;
      sel_b = (i < 4) ? `SPO_SEL_PFD_DIV2 : `SPO_SEL_REF_DIV2;
      reg_write(`SPO_CTRL_ADDR, {4'h0, 2'b11, 2'(i % 4)});
      a0 = n_a;
      b0 = n_b;
      k = 0;
      while ((n_a < a0 + 3 || n_b < b0 + 3) && k < 3000)
      begin
        @(negedge ref_clk);
        k++;
      end
      if (k >= 3000)
      begin
        fail_count++;
        complete_run();
      end
      // first edges after a switch are not measured: divider phase is arbitrary
      a0 = (sel_a == `SPO_SEL_REF_DIV2) ? 100 : 140;
      b0 = (sel_b == `SPO_SEL_REF_DIV2) ? 100 : 140;
      check(per_a, a0 * (ctrl_m[1] ? 4 : 1));
      check(per_b, b0 * (ctrl_m[0] ? 4 : 1));
    end
    $display("test dynamic codes done");
    complete_run();
  end
endmodule : spo_status_pin_ctrl_tb_top
